// ---- design/eep_array.sv ----
/*
 * Byte array of the EEPROM, held in flip-flops, with a page commit port.
 * Assumes commit pulses only while the slave holds off all bus traffic.
 */
`timescale 1ns/10ps
module eep_array import eep_pkg::*; #(
   parameter int ADDR_W = 8
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic commit,
   input wire logic [ADDR_W-EEP_PAGE_LSB_W-1:0] page_base,
   input wire logic [EEP_PAGE_BYTES-1:0][EEP_WORD_W-1:0] page_data,
   input wire logic [EEP_PAGE_BYTES-1:0] page_valid,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [EEP_WORD_W-1:0] rd_data
);

   typedef struct packed {
      logic [(2**ADDR_W)-1:0][EEP_WORD_W-1:0] mem;
   } eep_array_t;

   eep_array_t s;
   eep_array_t next_s;

   always_comb begin
      next_s = s;
      if (commit) begin
         // Only bytes actually received are committed
         for (int i = 0; i < EEP_PAGE_BYTES; i++) begin
            if (page_valid[i]) begin
               next_s.mem[{page_base, EEP_PAGE_LSB_W'(i)}] = page_data[i];
            end
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         s <= {(2**ADDR_W){EEP_ERASED}};
      end else begin
         s <= next_s;
      end
   end

   assign rd_data = s.mem[rd_addr];

endmodule : eep_array

// ---- design/eep_slave.sv ----
/*
 * Two-wire bus slave of a small serial EEPROM: byte and page write,
 * write cycle with ack polling, write protect, current, random and
 * sequential read.
 * Assumes scl, sda_in, write_protect and select pins are asynchronous
 * and much slower than clock; sda is open drain, wired outside.
 */
// Behaviour
// - Matching write address is acked, next byte loads the word pointer.
// - Byte write acks word address and then the data byte.
// - Internal write cycle starts at the stop ending a write.
// - During the write cycle all bus inputs are ignored.
// - Every complete received data byte is acked in a page write.
// - Pointer advances by one after each received data byte.
// - Beyond sixteen bytes the pointer wraps and overwrites earlier bytes.
// - Fewer than sixteen bytes commit only those bytes, at their addresses.
// - Polled address is not acked while busy, acked once done.
// - Write protect high: addresses acked, data not, no write cycle.
// - Write protect low: every location is writable.
// - Pointer holds last accessed address plus one.
// - Matching read address is acked, then eight bits from the pointer.
// - Master nack then stop ends a read; device releases and idles.
// - Each master ack during a read brings the next byte.
// - Read pointer walks the whole array and wraps to zero.
// - Upper four address bits match class, next three select or block.
// - On master nack the device stops sending and waits for stop.
// - All bytes travel most significant bit first.
`timescale 1ns/10ps
module eep_slave import eep_pkg::*; #(
   parameter int BLOCK_BITS = 0,
   parameter logic [3:0] DEV_CLASS = 4'h5, // Arbitrary value
   parameter int WRITE_CYCLES = EEP_WR_CYCLES
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic write_protect,
   input wire logic addr_select_bit0,
   input wire logic addr_select_bit1,
   input wire logic addr_select_bit2,
   output logic write_busy
);

   localparam int ADDR_W = EEP_WORD_W + BLOCK_BITS;
   localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
   localparam int PAGE_W = ADDR_W - EEP_PAGE_LSB_W;

   typedef struct packed {
      eep_pins_t sync1;
      eep_pins_t sync2;
      logic scl_prev;
      logic sda_prev;
      eep_phase_t phase;
      logic slot;
      logic ack;
      logic [2:0] bit_cnt;
      logic [EEP_WORD_W-1:0] shift;
      logic write_dir;
      logic [ADDR_W-1:0] ptr;
      logic [EEP_PAGE_BYTES-1:0][EEP_WORD_W-1:0] page_data;
      logic [EEP_PAGE_BYTES-1:0] page_valid;
      logic commit;
      logic [PAGE_W-1:0] commit_page;
      logic [CNT_W-1:0] busy_cnt;
      logic busy;
      logic sda_out;
      logic sda_oe_n;
   } eep_state_t;

   eep_state_t s;
   eep_state_t next_s;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic [EEP_WORD_W-1:0] rx_byte;
   logic [EEP_WORD_W-1:0] rd_data;
   logic load_rd;

   function automatic logic addr_match(input logic [EEP_WORD_W-1:0] b,
                                       input logic [EEP_SEL_W-1:0] sel);
      logic ok;
      ok = (b[EEP_WORD_W-1:EEP_CLASS_LSB] == DEV_CLASS);
      // Low select positions double as block bits on larger arrays
      for (int k = BLOCK_BITS; k < EEP_SEL_W; k++) begin
         if (b[EEP_SEL_LSB + k] != sel[k]) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction : addr_match

   // Edges are found on the second sync stage only
   assign scl_rise = s.sync2.scl & ~s.scl_prev;
   assign scl_fall = ~s.sync2.scl & s.scl_prev;
   assign start_cond = s.sync2.scl & s.scl_prev & s.sda_prev & ~s.sync2.sda;
   assign stop_cond = s.sync2.scl & s.scl_prev & ~s.sda_prev & s.sync2.sda;
   assign rx_byte = {s.shift[EEP_WORD_W-2:0], s.sync2.sda};

   always_comb begin
      next_s = s;
      load_rd = 1'b0;
      next_s.sync1 = '{scl: scl, sda: sda_in, wp: write_protect,
                       sel: {addr_select_bit2, addr_select_bit1, addr_select_bit0}};
      next_s.sync2 = s.sync1;
      next_s.scl_prev = s.sync2.scl;
      next_s.sda_prev = s.sync2.sda;
      next_s.commit = 1'b0;
      next_s.sda_out = 1'b0;
      // After a commit the buffer is emptied only once the array has taken it
      if (s.commit) begin
         next_s.page_valid = '0;
      end

      if (s.busy) begin
         // Bus is deaf while programming, so polls see no ack
         next_s.phase = EEP_IDLE;
         next_s.sda_oe_n = 1'b1;
         next_s.slot = 1'b0;
         if (s.busy_cnt == '0) begin
            next_s.busy = 1'b0;
         end else begin
            next_s.busy_cnt = s.busy_cnt - 1'b1;
         end
      end else if (start_cond) begin
         // Repeated start is handled the same way
         next_s.phase = EEP_DEV;
         next_s.bit_cnt = '0;
         // Bytes left from a write cut by a repeated start never commit
         next_s.page_valid = '0;
         next_s.slot = 1'b0;
         next_s.sda_oe_n = 1'b1;
      end else if (stop_cond) begin
         next_s.phase = EEP_IDLE;
         next_s.sda_oe_n = 1'b1;
         next_s.slot = 1'b0;
         if (s.write_dir && (|s.page_valid) && !s.sync2.wp) begin
            next_s.commit = 1'b1;
            next_s.commit_page = s.ptr[ADDR_W-1:EEP_PAGE_LSB_W];
            next_s.busy = 1'b1;
            next_s.busy_cnt = CNT_W'(WRITE_CYCLES - 1);
         end else begin
            next_s.page_valid = '0;
         end
         next_s.write_dir = 1'b0;
      end else begin
         unique case (s.phase)
            EEP_IDLE, EEP_WAIT_STOP: begin
               next_s.sda_oe_n = 1'b1;
            end
            EEP_DEV: begin
               if (scl_rise) begin
                  next_s.shift = rx_byte;
                  next_s.bit_cnt = s.bit_cnt + 1'b1;
                  if (s.bit_cnt == EEP_BIT_LAST) begin
                     if (addr_match(rx_byte, s.sync2.sel)) begin
                        next_s.phase = EEP_DEV_ACK;
                        next_s.ack = 1'b1;
                        next_s.write_dir = ~rx_byte[EEP_RW_BIT];
                        if (!rx_byte[EEP_RW_BIT]) begin
                           for (int k = 0; k < BLOCK_BITS; k++) begin
                              next_s.ptr[EEP_WORD_W + k] = rx_byte[EEP_SEL_LSB + k];
                           end
                        end
                     end else begin
                        next_s.phase = EEP_IDLE;
                     end
                  end
               end
            end
            EEP_DEV_ACK, EEP_WORD_ACK, EEP_DATA_ACK: begin
               if (scl_fall && !s.slot) begin
                  next_s.slot = 1'b1;
                  next_s.sda_oe_n = ~s.ack;
               end else if (scl_fall) begin
                  next_s.slot = 1'b0;
                  next_s.sda_oe_n = 1'b1;
                  next_s.bit_cnt = '0;
                  if (s.phase == EEP_DEV_ACK && !s.write_dir) begin
                     load_rd = 1'b1;
                  end else if (s.phase == EEP_DEV_ACK) begin
                     next_s.phase = EEP_WORD;
                  end else if (s.ack) begin
                     next_s.phase = EEP_DATA;
                  end else begin
                     next_s.phase = EEP_WAIT_STOP;
                  end
               end
            end
            EEP_WORD: begin
               if (scl_rise) begin
                  next_s.shift = rx_byte;
                  next_s.bit_cnt = s.bit_cnt + 1'b1;
                  if (s.bit_cnt == EEP_BIT_LAST) begin
                     next_s.ptr[EEP_WORD_W-1:0] = rx_byte;
                     next_s.page_valid = '0;
                     next_s.ack = 1'b1;
                     next_s.phase = EEP_WORD_ACK;
                  end
               end
            end
            EEP_DATA: begin
               if (scl_rise) begin
                  next_s.shift = rx_byte;
                  next_s.bit_cnt = s.bit_cnt + 1'b1;
                  if (s.bit_cnt == EEP_BIT_LAST) begin
                     next_s.phase = EEP_DATA_ACK;
                     if (s.sync2.wp) begin
                        next_s.ack = 1'b0;
                     end else begin
                        // Later bytes overwrite earlier ones in the buffer
                        next_s.page_data[s.ptr[EEP_PAGE_LSB_W-1:0]] = rx_byte;
                        next_s.page_valid[s.ptr[EEP_PAGE_LSB_W-1:0]] = 1'b1;
                        next_s.ptr[EEP_PAGE_LSB_W-1:0] =
                           s.ptr[EEP_PAGE_LSB_W-1:0] + 1'b1;
                        next_s.ack = 1'b1;
                     end
                  end
               end
            end
            EEP_RD_DATA: begin
               if (scl_rise) begin
                  next_s.bit_cnt = s.bit_cnt + 1'b1;
                  if (s.bit_cnt == EEP_BIT_LAST) begin
                     next_s.phase = EEP_RD_ACK;
                     next_s.slot = 1'b0;
                  end
               end else if (scl_fall) begin
                  next_s.shift = {s.shift[EEP_WORD_W-2:0], 1'b0};
                  next_s.sda_oe_n = s.shift[EEP_WORD_W-2];
               end
            end
            EEP_RD_ACK: begin
               if (scl_fall && !s.slot) begin
                  next_s.slot = 1'b1;
                  next_s.sda_oe_n = 1'b1;
               end else if (scl_rise && s.slot) begin
                  next_s.ack = ~s.sync2.sda;
                  if (s.sync2.sda) begin
                     next_s.phase = EEP_WAIT_STOP;
                  end
               end else if (scl_fall && s.ack) begin
                  next_s.slot = 1'b0;
                  load_rd = 1'b1;
               end
            end
            default: begin
               next_s.phase = EEP_IDLE;
               next_s.sda_oe_n = 1'b1;
            end
         endcase

         // Byte leaves on the fall; pointer walks the full array
         if (load_rd) begin
            next_s.shift = rd_data;
            next_s.sda_oe_n = rd_data[EEP_WORD_W-1];
            next_s.ptr = s.ptr + 1'b1;
            next_s.bit_cnt = '0;
            next_s.phase = EEP_RD_DATA;
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         s <= '0;
         // Idle bus is high; avoids a false start at release
         s.sync1.scl <= 1'b1;
         s.sync1.sda <= 1'b1;
         s.sync2.scl <= 1'b1;
         s.sync2.sda <= 1'b1;
         s.scl_prev <= 1'b1;
         s.sda_prev <= 1'b1;
         s.phase <= EEP_IDLE;
         s.sda_oe_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   eep_array #(
      .ADDR_W(ADDR_W)
   ) u_array (
      .clock(clock),
      .reset(reset),
      .commit(s.commit),
      .page_base(s.commit_page),
      .page_data(s.page_data),
      .page_valid(s.page_valid),
      .rd_addr(s.ptr),
      .rd_data(rd_data)
   );

   assign sda_out = s.sda_out;
   assign sda_oe_n = s.sda_oe_n;
   assign write_busy = s.busy;

endmodule : eep_slave

// ---- dv/eep_bus_master.sv ----
/*
 * Behavioural two-wire bus master, 48 ns bus clock.
 * Assumes a pull-up on data; clock only aligns frames off system edges.
 */
`timescale 1ns/10ps
module eep_bus_master (
   input wire logic clock,
   output logic scl,
   output logic sda_pull,
   input wire logic sda
);
   // Bus clock stands high between frames
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic start_cond;
      @(posedge clock);
      #0.1;
      sda_pull = 1'b0;
      #12 scl = 1'b1;
      #12 sda_pull = 1'b1;
      #12 scl = 1'b0;
      #12;
   endtask : start_cond
   task automatic stop_cond;
      sda_pull = 1'b1;
      #12 scl = 1'b1;
      #12 sda_pull = 1'b0;
      #24;
   endtask : stop_cond
   task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         sda_pull = ~tx[i];
         #12 scl = 1'b1;
         #12 rx[i] = sda;
         #12 scl = 1'b0;
         #12;
      end
   endtask : byte_io
endmodule : eep_bus_master

// ---- dv/eep_slave_sva.sv ----
/*
 * Port assertions of the serial EEPROM slave.
 * Assumes a single clock domain; bound to every eep_slave instance.
 */
`timescale 1ns/10ps
module eep_slave_sva import eep_pkg::*; #(
   parameter int WRITE_CYCLES = EEP_WR_CYCLES
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic scl,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic write_protect,
   input wire logic write_busy
);
   int busy_cnt;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= write_busy ? busy_cnt + 1 : 0;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   reset_quiet_a: assert property (disable iff (1'b0) reset |-> sda_oe_n && !write_busy)
      else $error("bus driven or busy in reset");
   low_only_a: assert property (!sda_oe_n |-> sda_out == 1'b0)
      else $error("data pin driven high");
   busy_quiet_a: assert property (write_busy |-> sda_oe_n)
      else $error("data driven during write cycle");
   busy_len_a: assert property ($fell(write_busy) |-> busy_cnt == WRITE_CYCLES)
      else $error("write cycle length wrong");
   busy_start_a: assert property ($rose(write_busy) |-> scl && sda_in && !$past(sda_in, 6))
      else $error("write cycle not started by stop");
   drive_edge_a: assert property (!$stable(sda_oe_n) |-> !scl)
      else $error("data changed while clock high");
   ack_hold_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
      else $error("low drive too short");
   wp_block_a: assert property (write_protect && $past(write_protect, 8) |-> !$rose(write_busy))
      else $error("write cycle while protected");
endmodule : eep_slave_sva

bind eep_slave eep_slave_sva #(.WRITE_CYCLES(WRITE_CYCLES)) i_sva (.clock(clock),
   .reset(reset), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
   .write_protect(write_protect), .write_busy(write_busy));

// ---- dv/tb_top.sv ----
/*
 * Self-checking bench of the EEPROM slave with a bus master model.
 * Assumes a pull-up on data and a shortened write cycle.
 */
`timescale 1ns/10ps
module tb_top import eep_pkg::*;;
   logic clock, reset, wp, sda_oe_n, sda_out, write_busy, ack_m;
   logic [2:0] sel;
   wire logic scl, pull, sda;
   int num_errors, total_checks, tb_ptr, polls;
   logic [7:0] exp_mem [256];
   logic [15:0] rows [4] = '{16'h00a5, 16'hff3c, 16'h5081, 16'h7e00};

   assign sda = ~(pull | ~sda_oe_n);
   eep_slave #(.WRITE_CYCLES(50)) i_dut (.clock(clock), .reset(reset), .scl(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .write_protect(wp),
      .addr_select_bit0(sel[0]), .addr_select_bit1(sel[1]), .addr_select_bit2(sel[2]),
      .write_busy(write_busy));
   eep_bus_master i_mst (.clock(clock), .scl(scl), .sda_pull(pull), .sda(sda));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      #200000;
      num_errors++;
      close_out();
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out
   task automatic done(input string name);
      $display("test %s done", name);
   endtask : done
   function automatic logic [7:0] dev(input logic rw);
      return {4'h5, sel, rw};
   endfunction : dev
   task automatic put(input logic [7:0] b, output logic ack);
      logic [8:0] rx;
      i_mst.byte_io({b, 1'b1}, rx);
      ack = (rx[0] === 1'b0);
   endtask : put

   task automatic wr(input logic [7:0] a, input int n, input logic [7:0] d0);
      logic ack;
      i_mst.start_cond();
      put(dev(1'b0), ack);
      check({7'h0, ack}, 8'h01);
      put(a, ack);
      check({7'h0, ack}, 8'h01);
      for (int i = 0; i < n; i++) begin
         put(d0 + 8'(i), ack);
         check({7'h0, ack}, {7'h0, ~wp});
         if (!wp) begin
            exp_mem[{a[7:4], 4'(a[3:0] + i)}] = d0 + 8'(i);
         end
      end
      tb_ptr = wp ? a : {a[7:4], 4'(a[3:0] + n)};
      i_mst.stop_cond();
      polls = 0;
      ack = 1'b0;
      while (!ack && polls < 100) begin
         i_mst.start_cond();
         put(dev(1'b0), ack);
         i_mst.stop_cond();
         polls++;
      end
      check({7'h0, ack}, 8'h01);
      check({7'h0, polls > 1}, {7'h0, ~wp});
   endtask : wr

   task automatic rd(input logic rnd, input logic [7:0] a, input int n);
      logic ack;
      logic [8:0] rx;
      if (rnd) begin
         i_mst.start_cond();
         put(dev(1'b0), ack);
         put(a, ack);
         check({7'h0, ack}, 8'h01);
         tb_ptr = a;
      end
      i_mst.start_cond();
      put(dev(1'b1), ack);
      check({7'h0, ack}, 8'h01);
      for (int i = 0; i < n; i++) begin
         i_mst.byte_io({8'hff, 1'(i == n - 1)}, rx);
         check(rx[8:1], exp_mem[8'(tb_ptr)]);
         tb_ptr = (tb_ptr + 1) % 256;
      end
      i_mst.stop_cond();
      check({7'h0, sda_oe_n}, 8'h01);
   endtask : rd

   initial begin
      reset = 1'b0;
      wp = 1'b0;
      sel = 3'h5;
      num_errors = 0;
      total_checks = 0;
      tb_ptr = 0;
      foreach (exp_mem[i]) exp_mem[i] = EEP_ERASED;
      // Raised after time zero so the asynchronous reset edge is never missed
      #1 reset = 1'b1;
      repeat (5) @(negedge clock);
      reset = 1'b0;
      check({6'h0, sda_oe_n, write_busy}, 8'h02);
      repeat (3) @(negedge clock);
      foreach (rows[r]) begin
         wr(rows[r][15:8], 1, rows[r][7:0]);
         rd(1'b1, rows[r][15:8], 1);
      end
      done("table");
      rd(1'b0, 8'h00, 1);
      rd(1'b1, 8'hff, 2);
      done("rollover");
      wr(8'h2e, 18, 8'h40);
      rd(1'b1, 8'h20, 17);
      wr(8'h45, 3, 8'h90);
      rd(1'b0, 8'h00, 1);
      rd(1'b1, 8'h44, 5);
      done("page");
      @(negedge clock);
      wp = 1'b1;
      wr(8'h60, 2, 8'h12);
      @(negedge clock);
      wp = 1'b0;
      rd(1'b1, 8'h60, 1);
      done("protect");
      for (int k = 0; k < 2; k++) begin
         i_mst.start_cond();
         put(k ? {4'h6, sel, 1'b1} : {4'h5, sel ^ 3'h1, 1'b0}, ack_m);
         check({7'h0, ack_m}, 8'h00);
         i_mst.stop_cond();
      end
      done("address");
      @(negedge clock);
      reset = 1'b1;
      foreach (exp_mem[i]) exp_mem[i] = EEP_ERASED;
      repeat (2) @(negedge clock);
      reset = 1'b0;
      check({6'h0, sda_oe_n, write_busy}, 8'h02);
      repeat (3) @(negedge clock);
      rd(1'b1, 8'h45, 1);
      done("reset");
      close_out();
   end
endmodule : tb_top

// ---- pkg/eep_pkg.sv ----
/*
 * Shared constants and carrier types of the serial EEPROM slave.
 * Assumes a single 200 MHz system clock; bus pins arrive asynchronously.
 */
package eep_pkg;

   localparam int EEP_WORD_W = 8;
   localparam int EEP_PAGE_BYTES = 16;
   localparam int EEP_PAGE_LSB_W = 4;
   localparam int EEP_SEL_W = 3;
   localparam int EEP_RW_BIT = 0;
   localparam int EEP_SEL_LSB = 1;
   localparam int EEP_CLASS_LSB = 4;
   localparam logic [2:0] EEP_BIT_LAST = 3'h7;
   localparam logic [7:0] EEP_ERASED = 8'hff;

   // Write cycle time and system clock period
   localparam longint EEP_T_WR_NS = 5000000;
   localparam longint EEP_CLK_NS = 5;
   localparam int EEP_WR_CYCLES = int'((EEP_T_WR_NS + EEP_CLK_NS - 1) / EEP_CLK_NS);

   typedef struct packed {
      logic scl;
      logic sda;
      logic wp;
      logic [EEP_SEL_W-1:0] sel;
   } eep_pins_t;

   typedef enum logic [3:0] {
      EEP_IDLE,
      EEP_DEV,
      EEP_DEV_ACK,
      EEP_WORD,
      EEP_WORD_ACK,
      EEP_DATA,
      EEP_DATA_ACK,
      EEP_RD_DATA,
      EEP_RD_ACK,
      EEP_WAIT_STOP
   } eep_phase_t;

endpackage : eep_pkg
